// File: spi_err_ctrl.sv
// byte serial controller: flags, requests, mode faults and partial reset
`timescale 1ns/1ps
// Function
// - overflow sets when received data is unread at bit 1 capture of next byte.
// - during overflow new bytes are dropped and receive full is not set.
// - overflow clears by a status read followed by a data read.
// - overflow and mode fault share the error request, gated by error enable.
// - master drives clock and MOSI, reads MISO; slave reverses the directions.
// - mode fault: select high mid-transfer as slave, or low as master.
// - clearing fault enable keeps the fault flag but blocks setting it again.
// - master fault disables module, sets tx empty, clears counter, releases pins.
// - slave transfer bounds depend on phase: select fall or first capture edge.
// - phase 0 select pulse without clocks faults; phase 1 does not.
// - a fault never changes master select; it is ignored while disabled.
// - slave fault neither disables nor resets; software may disable to abort.
// - select high makes slave MISO high impedance and clock edges ignored.
// - fault clears by status read then control write, unless fault persists.
// - tx request is tx empty while tx enable and module enable are set.
// - rx request is receive full with rx enable, whatever module enable.
// - receive full clears by status then data read; tx empty by data write.
// - receive full sets on each byte received outside overflow; tx empty on each shift load.
// - while disabled: tx empty set, transfer aborted, shift and counter cleared.
// - control bits and the three flags survive disabling; system reset only.
module spi_err_ctrl (
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic                           link_sck,
  input  wire logic                           ss_n_i,
  input  wire logic                           mosi_i,
  input  wire logic                           miso_i,
  output logic                                sck_o,
  output logic                                sck_oe,
  output logic                                mosi_o,
  output logic                                mosi_oe,
  output logic                                miso_o,
  output logic                                miso_oe,
  input  wire logic                           ctrl_wr,
  input  wire logic                           wr_module_enable,
  input  wire logic                           wr_master_select,
  input  wire logic                           wr_cpol,
  input  wire logic                           wr_cpha,
  input  wire logic                           wr_tx_irq_enable,
  input  wire logic                           wr_rx_irq_enable,
  input  wire logic                           scr_wr,
  input  wire logic                           wr_error_irq_enable,
  input  wire logic                           wr_mode_fault_enable,
  input  wire logic [spi_err_pkg::RATE_W-1:0] wr_rate_select,
  input  wire logic                           status_rd,
  input  wire logic                           data_rd,
  input  wire logic                           data_wr,
  input  wire logic [spi_err_pkg::BYTE_W-1:0] wr_data,
  output logic      [spi_err_pkg::BYTE_W-1:0] rx_data,
  output logic                                overflow_flag,
  output logic                                receive_full_flag,
  output logic                                mode_fault_flag,
  output logic                                tx_empty_flag,
  output logic                                module_enable,
  output logic                                master_select,
  output logic                                tx_irq,
  output logic                                rx_err_irq
);
  import spi_err_pkg::*;

  function automatic logic [DIV_W-1:0] half_period(input logic [RATE_W-1:0] rate);
    case (rate)
      RATE_DIV2:  half_period = HALF_DIV2;
      RATE_DIV8:  half_period = HALF_DIV8;
      RATE_DIV32: half_period = HALF_DIV32;
      default:    half_period = HALF_DIV128;
    endcase
  endfunction : half_period

  ////////////////////////////////////////////////////////////////////////////
  // control bits, kept across disable
  logic              en_r, master_r, cpol_r, cpha_r, txie_r, rxie_r;
  logic              error_irq_enable_r, mfe_r;
  logic [RATE_W-1:0] rate_r;
  logic              mst_fault;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {master_r, cpol_r, cpha_r, txie_r, rxie_r} <= '0;
      {error_irq_enable_r, mfe_r} <= '0;
      rate_r <= RATE_DIV2;
    end else begin
      if (ctrl_wr) begin
        master_r <= wr_master_select;
        cpol_r   <= wr_cpol;
        cpha_r   <= wr_cpha;
        txie_r   <= wr_tx_irq_enable;
        rxie_r   <= wr_rx_irq_enable;
      end
      if (scr_wr) begin
        error_irq_enable_r <= wr_error_irq_enable;
        mfe_r   <= wr_mode_fault_enable;
        rate_r  <= wr_rate_select;
      end
    end
  end

  // a master fault wins over a same-cycle enable write
  wire en_nxt = mst_fault ? 1'b0 : (ctrl_wr ? wr_module_enable : en_r);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) en_r <= 1'b0;
    else         en_r <= en_nxt;
  end

  wire master_on = en_r & master_r;
  wire slave_on  = en_r & ~master_r;

  ////////////////////////////////////////////////////////////////////////////
  // pin and toggle synchronisers
  logic       ss_m_r, ss_s_r, ss_d_r, mi_m_r, mi_s_r;
  logic [2:0] lk_tg_r, tg_m_r, tg_s_r, tg_d_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {ss_m_r, ss_s_r, ss_d_r} <= 3'h7;
      {mi_m_r, mi_s_r} <= 2'h0;
      {tg_m_r, tg_s_r, tg_d_r} <= '0;
    end else begin
      {ss_m_r, ss_s_r, ss_d_r} <= {ss_n_i, ss_m_r, ss_s_r};
      {mi_m_r, mi_s_r} <= {miso_i, mi_m_r};
      {tg_m_r, tg_s_r, tg_d_r} <= {lk_tg_r, tg_m_r, tg_s_r};
    end
  end

  wire [2:0] lk_ev   = tg_s_r ^ tg_d_r;
  wire       ss_rise = ss_s_r & ~ss_d_r;
  wire       ss_fall = ~ss_s_r & ss_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // slave transfer tracking
  logic sl_busy_r;
  wire  sl_done  = slave_on & lk_ev[TG_DONE];
  wire  sl_b1    = slave_on & lk_ev[TG_BIT1];
  wire  sl_begin = cpha_r ? lk_ev[TG_START] : ss_fall;
  wire  sl_busy_nxt = !slave_on ? 1'b0 :
                      (sl_done | ss_s_r) ? 1'b0 :
                      (sl_begin ? 1'b1 : sl_busy_r);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) sl_busy_r <= 1'b0;
    else         sl_busy_r <= sl_busy_nxt;
  end

  // phase 0 is busy from select fall, so a bare select pulse still faults
  wire sl_fault  = slave_on & ss_rise & sl_busy_r;
  assign mst_fault = mfe_r & master_on & ~ss_s_r;
  wire mf_cond   = mst_fault | (mfe_r & sl_fault);

  ////////////////////////////////////////////////////////////////////////////
  // master engine: bit clock divider and edge counter
  mst_state_t       m_st_r;
  logic [DIV_W-1:0] m_div_r;
  logic [3:0]       m_e_r;
  logic [7:0]       sh_r, m_rx_r, txd_r, sl_tx_r;
  logic             sck_r, txe_r;

  wire m_tick    = (m_st_r == M_RUN) & (m_div_r == DIV_ZERO);
  wire m_capture = m_tick & (m_e_r[0] == cpha_r);
  wire m_launch  = m_tick & ~m_capture & (m_e_r != EDGE_ZERO);
  wire m_b1      = m_capture & (m_e_r[3:1] == BIT1_CAPTURE);
  wire m_done    = (m_st_r == M_DONE);
  wire m_load    = master_on & ~txe_r & (m_st_r == M_IDLE);
  wire s_load    = slave_on & ~txe_r & ~sl_busy_r & ss_s_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m_st_r  <= M_IDLE;
      m_div_r <= DIV_ZERO;
      m_e_r   <= EDGE_ZERO;
      sck_r   <= 1'b0;
    end else if (!master_on || mst_fault) begin
      m_st_r  <= M_IDLE;
      m_e_r   <= EDGE_ZERO;
      sck_r   <= cpol_r;
    end else begin
      case (m_st_r)
        M_IDLE: if (m_load) begin
          m_st_r  <= M_RUN;
          m_div_r <= half_period(rate_r) - DIV_ONE;
          m_e_r   <= EDGE_ZERO;
        end
        M_RUN: if (m_tick) begin
          sck_r   <= ~sck_r;
          m_div_r <= half_period(rate_r) - DIV_ONE;
          m_e_r   <= m_e_r + EDGE_ONE;
          if (m_e_r == LAST_EDGE) m_st_r <= M_DONE;
        end else begin
          m_div_r <= m_div_r - DIV_ONE;
        end
        M_DONE: m_st_r <= M_IDLE;
        default: m_st_r <= M_IDLE;
      endcase
    end
  end

  // shift registers are cleared, not just frozen, whenever disabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {sh_r, m_rx_r, sl_tx_r} <= '0;
    end else if (!en_r) begin
      {sh_r, m_rx_r, sl_tx_r} <= '0;
    end else begin
      if (m_load)         sh_r <= txd_r;
      else if (m_launch)  sh_r <= {sh_r[6:0], 1'b0};
      if (m_capture)      m_rx_r <= {m_rx_r[6:0], mi_s_r};
      if (s_load)         sl_tx_r <= txd_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)      txd_r <= BYTE_ZERO;
    else if (data_wr) txd_r <= wr_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side: slave shifter on the incoming serial clock
  logic [2:0] lk_cnt_r;
  logic [7:0] lk_sh_r, lk_byte_r;
  wire        cap_clk  = link_sck ^ cpol_r ^ cpha_r;
  wire        lk_act   = ~ss_n_i & slave_on;
  // select high holds the counter in reset, so stray edges do nothing
  wire        lk_rst_n = resetn & lk_act;

  always_ff @(posedge cap_clk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_cnt_r <= FIRST_BIT;
      lk_sh_r  <= BYTE_ZERO;
    end else begin
      lk_cnt_r <= lk_cnt_r + BIT_ONE;
      lk_sh_r  <= {lk_sh_r[6:0], mosi_i};
    end
  end

  // toggles survive select, so no event is lost or invented by the reset
  always_ff @(posedge cap_clk or negedge resetn) begin
    if (!resetn) begin
      lk_tg_r   <= TGL_ZERO;
      lk_byte_r <= BYTE_ZERO;
    end else if (lk_act) begin
      if (lk_cnt_r == FIRST_BIT)    lk_tg_r[TG_START] <= ~lk_tg_r[TG_START];
      if (lk_cnt_r == BIT1_CAPTURE) lk_tg_r[TG_BIT1]  <= ~lk_tg_r[TG_BIT1];
      if (lk_cnt_r == LAST_BIT) begin
        lk_tg_r[TG_DONE] <= ~lk_tg_r[TG_DONE];
        lk_byte_r        <= {lk_sh_r[6:0], mosi_i};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags; a hardware set always wins over a software clear
  logic       ovf_r, rxf_r, mf_r, ov_arm_r, rf_arm_r, mf_arm_r;
  logic [7:0] rx_r;

  wire       b1_ev    = sl_b1 | m_b1;
  wire       done_ev  = sl_done | m_done;
  // link byte stays put for a whole byte time, long after the toggle lands
  wire [7:0] rx_byte  = master_on ? m_rx_r : lk_byte_r;
  wire       rx_take  = done_ev & ~ovf_r;

  wire ovf_nxt = (b1_ev & rxf_r) ? 1'b1 :
                 ((data_rd & ov_arm_r) ? 1'b0 : ovf_r);
  wire rxf_nxt = rx_take ? 1'b1 :
                 ((data_rd & rf_arm_r) ? 1'b0 : rxf_r);
  wire mf_nxt  = mf_cond ? 1'b1 :
                 ((ctrl_wr & mf_arm_r) ? 1'b0 : mf_r);
  wire txe_nxt = (!en_r | m_load | s_load | mst_fault) ? 1'b1 :
                 (data_wr ? 1'b0 : txe_r);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {ovf_r, rxf_r, mf_r} <= '0;
      txe_r <= 1'b1;
    end else begin
      {ovf_r, rxf_r, mf_r} <= {ovf_nxt, rxf_nxt, mf_nxt};
      txe_r <= txe_nxt;
    end
  end

  // first step of each two-step clear; a persisting fault disarms it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {ov_arm_r, rf_arm_r, mf_arm_r} <= '0;
    end else begin
      ov_arm_r <= data_rd ? 1'b0 : (ov_arm_r | (status_rd & ovf_r));
      rf_arm_r <= data_rd ? 1'b0 : (rf_arm_r | (status_rd & rxf_r));
      mf_arm_r <= (ctrl_wr | mf_cond) ? 1'b0 : (mf_arm_r | (status_rd & mf_r));
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)      rx_r <= BYTE_ZERO;
    else if (rx_take) rx_r <= rx_byte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs and requests
  assign rx_data           = rx_r;
  assign overflow_flag     = ovf_r;
  assign receive_full_flag = rxf_r;
  assign mode_fault_flag   = mf_r;
  assign tx_empty_flag     = txe_r;
  assign module_enable     = en_r;
  assign master_select     = master_r;
  assign tx_irq     = txe_r & txie_r & en_r;
  assign rx_err_irq = (rxf_r & rxie_r) | ((ovf_r | mf_r) & error_irq_enable_r);

  // pins go back to port control whenever disabled
  assign sck_o   = sck_r;
  assign sck_oe  = master_on;
  assign mosi_o  = sh_r[7];
  assign mosi_oe = master_on;
  // select lags two bus clocks through its synchroniser
  assign miso_o  = sl_tx_r[~lk_cnt_r];
  assign miso_oe = slave_on & ~ss_s_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_ovf_armed;
    status_rd && ovf_r && !data_rd && !b1_ev;
  endsequence

  sequence s_mf_armed;
    status_rd && mf_r && !ctrl_wr && !mf_cond;
  endsequence

  a_ovf_sets: assert property ((b1_ev && rxf_r) |=> ovf_r)
    else $error("overflow not set at bit 1 capture with data unread");
  a_rx_blocked: assert property ((done_ev && ovf_r) |=> $stable(rx_r) && rxf_r == $past(rxf_r)
    || (rxf_r == 1'b0)) else $error("byte moved in during overflow");
  a_ovf_clear: assert property ((s_ovf_armed ##1 (data_rd && !b1_ev)) |=> !ovf_r)
    else $error("overflow not cleared by status then data read");
  a_err_request: assert property ($rose(ovf_r) && error_irq_enable_r |-> rx_err_irq ##1 (rx_err_irq || !ovf_r))
    else $error("error request missing");
  a_master_fault: assert property (mst_fault |=> !en_r && txe_r && m_e_r == EDGE_ZERO && !sck_oe)
    else $error("master fault did not shut down");
  a_slave_keeps: assert property ((sl_fault && !ctrl_wr) |=> en_r && $stable(master_r))
    else $error("slave fault changed enable or mode");
  a_miso_float: assert property (ss_s_r |-> !miso_oe ##1 !sl_busy_r)
    else $error("slave drives output while deselected");
  a_mf_clear: assert property ((s_mf_armed ##1 (ctrl_wr && !mf_cond)) |=> !mf_r)
    else $error("mode fault not cleared by status read then control write");
  a_disable_empty: assert property (!en_r |=> txe_r && m_st_r == M_IDLE ##1 sh_r == BYTE_ZERO)
    else $error("disabled controller not reset");
  a_tx_request: assert property (tx_irq |-> en_r && txe_r && txie_r)
    else $error("tx request without enable");

endmodule : spi_err_ctrl

// File: spi_err_pkg.sv
// shared constants and types for the serial controller error and reset logic
package spi_err_pkg;

  localparam int          BYTE_W       = 8;
  localparam int          RATE_W       = 2;
  localparam int          DIV_W        = 7;
  localparam int          EDGE_W       = 4;
  localparam int          BIT_W        = 3;

  // half of one serial bit time in bus clocks, per rate code
  localparam logic [6:0]  HALF_DIV2    = 7'h01;
  localparam logic [6:0]  HALF_DIV8    = 7'h04;
  localparam logic [6:0]  HALF_DIV32   = 7'h10;
  localparam logic [6:0]  HALF_DIV128  = 7'h40;

  localparam logic [1:0]  RATE_DIV2    = 2'h0;
  localparam logic [1:0]  RATE_DIV8    = 2'h1;
  localparam logic [1:0]  RATE_DIV32   = 2'h2;

  localparam logic [3:0]  LAST_EDGE    = 4'hf;
  localparam logic [2:0]  BIT1_CAPTURE = 3'h6;
  localparam logic [2:0]  LAST_BIT     = 3'h7;
  localparam logic [2:0]  FIRST_BIT    = 3'h0;

  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  localparam logic [6:0]  DIV_ZERO     = 7'h00;
  localparam logic [6:0]  DIV_ONE      = 7'h01;
  localparam logic [3:0]  EDGE_ZERO    = 4'h0;
  localparam logic [3:0]  EDGE_ONE     = 4'h1;
  localparam logic [2:0]  BIT_ONE      = 3'h1;
  localparam logic [2:0]  TGL_ZERO     = 3'h0;

  // toggle lanes carried from the link side
  localparam int          TG_START     = 0;
  localparam int          TG_BIT1      = 1;
  localparam int          TG_DONE      = 2;

  typedef enum logic [1:0] {
    M_IDLE = 2'h0,
    M_RUN  = 2'h1,
    M_DONE = 2'h3
  } mst_state_t;

endpackage : spi_err_pkg

// File: spi_far_end.sv
// far-end serial partner: link master toward the slave side, slave toward the master side
`timescale 1ns/1ps
module spi_far_end (
  output logic      link_sck,
  output logic      ss_n,
  output logic      mosi,
  output logic      miso,
  input  wire logic sck_in,
  input  wire logic mosi_in,
  input  wire logic miso_in
);
  logic [7:0] reply;
  logic [7:0] got;
  logic [7:0] so;

  initial begin
    link_sck = 1'b0;
    ss_n     = 1'b1;
    mosi     = 1'b0;
    reply    = 8'h00;
    got      = 8'h00;
    so       = 8'h00;
  end

  ////////////////////////////////////////////////////////////////
  // slave answer to a master design: capture on rise, launch on fall
  assign miso = reply[7];
  always @(posedge sck_in) got <= {got[6:0], mosi_in};
  always @(negedge sck_in) reply <= {reply[6:0], ~reply[0]};

  ////////////////////////////////////////////////////////////////
  // link clock stands at its idle level outside frames; fewer than 8 bits leaves select rising mid-frame
  task automatic frame(input logic [7:0] d, input int nbits, input bit cpha, input bit cpol);
    link_sck = cpol;
    #40 ss_n = 1'b0;
    #40;
    for (int i = 7; i > 7 - nbits; i--) begin
      if (cpha) link_sck = ~cpol;
      mosi = d[i];
      // sample the slave output just before its bit counter moves on
      #7.5 so = {so[6:0], miso_in};
      link_sck = cpha ? cpol : ~cpol;
      #7.5 link_sck = cpol;
    end
    // give the crossing time to finish before select returns high
    #400 ss_n = 1'b1;
    mosi = ~mosi;
    #400;
  endtask : frame
endmodule : spi_far_end

// File: tb_spi_err_ctrl.sv
// self-checking bench for the serial controller flags, requests and partial reset
`timescale 1ns/1ps
module tb_spi_err_ctrl;
  import spi_err_pkg::*;
  logic       clk, resetn, link_sck, ss_n_i, mosi_i, miso_i;
  logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic       ctrl_wr, wr_module_enable, wr_master_select, wr_cpol, wr_cpha;
  logic       wr_tx_irq_enable, wr_rx_irq_enable, scr_wr, wr_error_irq_enable;
  logic       wr_mode_fault_enable, status_rd, data_rd, data_wr;
  logic [1:0] wr_rate_select;
  logic [7:0] wr_data, rx_data, b1, b2;
  logic       overflow_flag, receive_full_flag, mode_fault_flag, tx_empty_flag;
  logic       module_enable, master_select, tx_irq, rx_err_irq;
  int         miscompares, comparisons;

  spi_err_ctrl spi_err_ctrl_inst (
    .clk(clk), .resetn(resetn), .link_sck(link_sck), .ss_n_i(ss_n_i), .mosi_i(mosi_i),
    .miso_i(miso_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_o(miso_o), .miso_oe(miso_oe), .ctrl_wr(ctrl_wr), .wr_module_enable(wr_module_enable),
    .wr_master_select(wr_master_select), .wr_cpol(wr_cpol), .wr_cpha(wr_cpha),
    .wr_tx_irq_enable(wr_tx_irq_enable), .wr_rx_irq_enable(wr_rx_irq_enable), .scr_wr(scr_wr),
    .wr_error_irq_enable(wr_error_irq_enable), .wr_mode_fault_enable(wr_mode_fault_enable),
    .wr_rate_select(wr_rate_select), .status_rd(status_rd), .data_rd(data_rd), .data_wr(data_wr),
    .wr_data(wr_data), .rx_data(rx_data), .overflow_flag(overflow_flag),
    .receive_full_flag(receive_full_flag), .mode_fault_flag(mode_fault_flag),
    .tx_empty_flag(tx_empty_flag), .module_enable(module_enable), .master_select(master_select),
    .tx_irq(tx_irq), .rx_err_irq(rx_err_irq)
  );

  spi_far_end spi_far_end_inst (
    .link_sck(link_sck), .ss_n(ss_n_i), .mosi(mosi_i), .miso(miso_i), .sck_in(sck_o), .mosi_in(mosi_o),
    .miso_in(miso_o)
  );

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  function automatic logic exp_rx_irq(input logic rf, input logic ov, input logic mf);
    return (rf & wr_rx_irq_enable) | ((ov | mf) & wr_error_irq_enable);
  endfunction : exp_rx_irq

  task automatic flags(input logic rf, input logic ov, input logic mf, input logic te, input logic en);
    chk("receive_full_flag", {7'h0, receive_full_flag}, {7'h0, rf});
    chk("overflow_flag", {7'h0, overflow_flag}, {7'h0, ov});
    chk("mode_fault_flag", {7'h0, mode_fault_flag}, {7'h0, mf});
    chk("tx_empty_flag", {7'h0, tx_empty_flag}, {7'h0, te});
    chk("module_enable", {7'h0, module_enable}, {7'h0, en});
    chk("tx_irq", {7'h0, tx_irq}, {7'h0, te & wr_tx_irq_enable & en});
    chk("rx_err_irq", {7'h0, rx_err_irq}, {7'h0, exp_rx_irq(rf, ov, mf)});
  endtask : flags

  task automatic cfg(input logic en, input logic mst, input logic cpha, input logic cpol);
    @(negedge clk);
    wr_module_enable = en;
    wr_master_select = mst;
    wr_cpha = cpha;
    wr_cpol = cpol;
    ctrl_wr = 1'b1;
    @(negedge clk);
    ctrl_wr = 1'b0;
  endtask : cfg

  // two-step clear: status read, then data read or control write
  task automatic clr(input bit by_data);
    @(negedge clk);
    status_rd = 1'b1;
    @(negedge clk);
    status_rd = 1'b0;
    data_rd = by_data;
    ctrl_wr = ~by_data;
    @(negedge clk);
    data_rd = 1'b0;
    ctrl_wr = 1'b0;
    @(negedge clk);
  endtask : clr

  task automatic scr(input logic fault_en);
    @(negedge clk);
    wr_mode_fault_enable = fault_en;
    scr_wr = 1'b1;
    @(negedge clk);
    scr_wr = 1'b0;
  endtask : scr

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////
  initial begin
    #2_000_000;
    miscompares++;
    results();
  end

  initial begin
    void'($urandom(79734));
    {clk, resetn, ctrl_wr, scr_wr, status_rd, data_rd, data_wr} = 7'h00;
    {wr_module_enable, wr_master_select, wr_cpol, wr_cpha} = 4'h0;
    {wr_tx_irq_enable, wr_rx_irq_enable, wr_error_irq_enable} = 3'h7;
    wr_mode_fault_enable = 1'b1;
    wr_rate_select = RATE_DIV8;
    wr_data = 8'h00;
    repeat (3) @(posedge clk);
    @(negedge clk) resetn = 1'b1;
    flags(0, 0, 0, 1, 0);
    scr(1'b1);
    cfg(1, 0, 0, 0);
    flags(0, 0, 0, 1, 1);
    @(negedge clk) data_wr = 1'b1;
    wr_data = 8'($urandom);
    @(negedge clk) data_wr = 1'b0;
    chk("tx_empty_flag", {7'h0, tx_empty_flag}, 8'h00);
    repeat (6) @(negedge clk);
    chk("tx_empty_flag", {7'h0, tx_empty_flag}, 8'h01);
    // slave bytes with corner values first
    for (int k = 0; k < 6; k++) begin
      b1 = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      spi_far_end_inst.frame(b1, 8, 0, 0);
      flags(1, 0, 0, 1, 1);
      chk("rx_data", rx_data, b1);
      chk("miso_oe", {7'h0, miso_oe}, 8'h00);
      chk("miso byte", spi_far_end_inst.so, wr_data);
      clr(1);
      flags(0, 0, 0, 1, 1);
    end
    // overflow boundary at the bit 1 capture, with select rising mid-frame
    b1 = 8'($urandom);
    spi_far_end_inst.frame(b1, 8, 0, 0);
    spi_far_end_inst.frame(8'($urandom), 6, 0, 0);
    flags(1, 0, 1, 1, 1);
    clr(0);
    flags(1, 0, 0, 1, 1);
    spi_far_end_inst.frame(8'($urandom), 7, 0, 0);
    flags(1, 1, 1, 1, 1);
    spi_far_end_inst.frame(8'($urandom), 8, 0, 0);
    chk("rx_data", rx_data, b1);
    flags(1, 1, 1, 1, 1);
    clr(1);
    flags(0, 0, 1, 1, 1);
    clr(0);
    // select pulse without clocks, phase 0, then fault enable off
    spi_far_end_inst.frame(8'h00, 0, 0, 0);
    flags(0, 0, 1, 1, 1);
    chk("master_select", {7'h0, master_select}, 8'h00);
    scr(1'b0);
    flags(0, 0, 1, 1, 1);
    clr(0);
    spi_far_end_inst.frame(8'h00, 0, 0, 0);
    flags(0, 0, 0, 1, 1);
    scr(1'b1);
    // phase 1, polarity 1
    cfg(0, 0, 1, 1);
    cfg(1, 0, 1, 1);
    spi_far_end_inst.frame(8'h00, 0, 1, 1);
    flags(0, 0, 0, 1, 1);
    b1 = 8'($urandom);
    spi_far_end_inst.frame(b1, 8, 1, 1);
    chk("rx_data", rx_data, b1);
    clr(1);
    spi_far_end_inst.frame(8'($urandom), 3, 1, 1);
    flags(0, 0, 1, 1, 1);
    clr(0);
    // master transfer, then a master mode fault
    cfg(0, 1, 0, 0);
    chk("sck_oe", {7'h0, sck_oe}, 8'h00);
    cfg(1, 1, 0, 0);
    chk("pin enables", {5'h0, sck_oe, mosi_oe, miso_oe}, 8'h06);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    spi_far_end_inst.reply = b2;
    @(negedge clk) data_wr = 1'b1;
    wr_data = b1;
    @(negedge clk) data_wr = 1'b0;
    for (int w = 0; w < 400 && receive_full_flag !== 1'b1; w++) @(negedge clk);
    chk("rx_data", rx_data, b2);
    chk("mosi byte", spi_far_end_inst.got, b1);
    spi_far_end_inst.frame(8'h00, 0, 0, 0);
    flags(1, 0, 1, 1, 0);
    chk("master_select", {7'h0, master_select}, 8'h01);
    chk("sck_oe", {7'h0, sck_oe}, 8'h00);
    // the control write that clears the fault must not re-enable the module
    wr_module_enable = 1'b0;
    clr(1);
    clr(0);
    flags(0, 0, 0, 1, 0);
    results();
  end
endmodule : tb_spi_err_ctrl
